/* hdl/gbc_defines.svh */
// Offsets, field positions, reset values and bus command codes
`ifndef GBC_DEFINES_SVH
`define GBC_DEFINES_SVH

// Register byte offsets
`define GBC_CTRL_OFS 4'h0
`define GBC_STATUS_OFS 4'h4
`define GBC_STB_OFS 4'h8

// Control register fields
`define GBC_CTRL_ARM_BUS 0
`define GBC_CTRL_ARM_MAN 1
`define GBC_CTRL_AUTO_OFF 2
`define GBC_CTRL_ADDR_LSB 8
`define GBC_CTRL_ADDR_MSB 12
`define GBC_ADDR_RST 5'h19

// Status register fields
`define GBC_ST_REMOTE 0
`define GBC_ST_LOCKOUT 1
`define GBC_ST_TALK 2
`define GBC_ST_LISTEN 3
`define GBC_ST_SRQ 4
`define GBC_ST_SPOLL 5

// Status byte request-service position
`define GBC_STB_RSV 6

// Multiline bus commands, ATN true, seven bits
`define GBC_CMD_GTL 7'h01
`define GBC_CMD_SDC 7'h04
`define GBC_CMD_GET 7'h08
`define GBC_CMD_LLO 7'h11
`define GBC_CMD_DCL 7'h14
`define GBC_CMD_SPE 7'h18
`define GBC_CMD_SPD 7'h19
`define GBC_CMD_UNL 7'h3f
`define GBC_CMD_UNT 7'h5f
`define GBC_GRP_LISTEN 2'b01
`define GBC_GRP_TALK 2'b10

`endif

/* hdl/gbc_pkg.sv */
// Types shared by the bus command state logic
package gbc_pkg;

  // Software configuration, untouched by clears
  typedef struct packed {
    logic [4:0] addr;
    logic auto_off;
    logic arm_manual;
    logic arm_bus;
  } gbc_cfg_t;

  // Interface state flags
  typedef struct packed {
    logic spoll;
    logic srq;
    logic listen;
    logic talk;
    logic lockout;
    logic remote;
  } gbc_ifst_t;

  // Decoded bus command strobes
  typedef struct packed {
    logic mla;
    logic mta;
    logic unl;
    logic unt;
    logic gtl;
    logic sdc;
    logic get;
    logic llo;
    logic dcl;
    logic spe;
    logic spd;
  } gbc_cmd_t;

endpackage

/* hdl/gbc_top.sv */
// Bus command state logic: remote/local, lockout, talker/listener, clears, poll
//
// How it works
// - Remote entered only on own listen address while remote enable asserted.
// - Interface clear forces local, talker idle, listener idle, indicators off; the code leaves the lockout and service request indicators as they were.
// - Interface clear leaves settings, stored data and event registers alone.
// - Interface clear before auto output-off leaves the output on.
// - Lockout ignores every panel control but output-off; local key useless.
// - Go-to-local leaves remote, cancels lockout; power-up also clears lockout.
// - Device clear empties buffers, cancels deferred and blocking commands, unaddressed.
// - Device clear leaves settings and stored data unchanged.
// - Selected device clear acts like device clear only when addressed.
// - Group trigger arms only when bus is arm source, else ignored.
// - Serial poll answers status byte at any time.
// - Trigger-and-acquire commands accepted only in remote.
// - Remote locks keys except local and output (trigger too under manual arming), lights remote indicator; leaving restores.
// - In remote output key works; trigger key works under manual arming.
// - Talker active on own talk address; idle on untalk, listen, clear.
// - Listener active on own listen address; idle on unlisten, talk, clear.
// - Service request indicator holds until poll byte read or causes clear.
// - Local key cancels remote, restores display; no effect under lockout.
// - Under lockout the output key can still switch the output off.
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "gbc_defines.svh"

module gbc_top
  import gbc_pkg::*;
#(
  parameter int NKEY = 4
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Bus management lines, pins
  input wire logic REN_N,
  input wire logic IFC_N,
  output logic SRQ_O,
  output logic SRQ_OE_N,
  // Command and talk side of the handshake engine
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_BYTE,
  input wire logic TALK_RD,
  // Status layer
  input wire logic [7:0] STB_IN,
  input wire logic SRQ_COND,
  output logic [7:0] SPOLL_BYTE,
  // Front panel keys, pins, high when pressed
  input wire logic KEY_LOCAL,
  input wire logic KEY_OUTPUT,
  input wire logic KEY_TRIG,
  input wire logic [NKEY-1:0] KEY_OTHER,
  // Measurement and output layer
  input wire logic MEAS_CMD,
  input wire logic MEAS_DONE,
  input wire logic OUTPUT_IS_ON,
  output logic MEAS_START,
  output logic MEAS_REJECT,
  output logic MEAS_ABORT,
  output logic ARM_EVENT,
  output logic OUT_SET_ON,
  output logic OUT_SET_OFF,
  output logic TRIG_KEY_EV,
  output logic [NKEY-1:0] PANEL_KEY_EV,
  // Message queues and display
  output logic DEV_CLEAR,
  output logic DISP_RESTORE,
  // Indicators
  output logic REMOTE_IND,
  output logic TALK_IND,
  output logic LISTEN_IND,
  output logic SRQ_IND,
  output logic LOCKOUT_IND
);

  localparam int SW = NKEY + 5;

  gbc_cfg_t cfg_q;
  gbc_ifst_t st_q;
  gbc_cmd_t cmd;
  logic [SW-1:0] raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] prev_q;
  logic [SW-1:0] press;
  logic ren;
  logic ifc;
  logic ifc_rise;
  logic k_local;
  logic k_output;
  logic k_trig;
  logic [NKEY-1:0] k_other;
  logic [6:0] cb;
  logic own_addr;
  logic ack_q;
  logic req;
  logic wr_en;
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  logic cond_q;
  logic poll_rd;
  logic [7:0] stb_q;

  // Pins inverted ahead of the first flop so bus lines read active high
  assign raw = {KEY_OTHER, KEY_TRIG, KEY_OUTPUT, KEY_LOCAL, ~IFC_N, ~REN_N};

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  assign press = sync2_q & ~prev_q;
  assign ren = sync2_q[0];
  assign ifc = sync2_q[1];
  assign ifc_rise = press[1];
  assign k_local = press[2];
  assign k_output = press[3];
  assign k_trig = press[4];
  assign k_other = press[SW-1:5];

  // Command decode; bit 7 of the byte is parity on some controllers
  assign cb = CMD_BYTE[6:0];
  assign own_addr = (cb[4:0] == cfg_q.addr);

  always_comb begin
    cmd = '0;
    if (CMD_VALID && !ifc) begin
      cmd.mla = (cb[6:5] == `GBC_GRP_LISTEN) && own_addr && (cb != `GBC_CMD_UNL);
      cmd.mta = (cb[6:5] == `GBC_GRP_TALK) && own_addr && (cb != `GBC_CMD_UNT);
      cmd.unl = (cb == `GBC_CMD_UNL);
      cmd.unt = (cb == `GBC_CMD_UNT);
      cmd.gtl = (cb == `GBC_CMD_GTL);
      cmd.sdc = (cb == `GBC_CMD_SDC);
      cmd.get = (cb == `GBC_CMD_GET);
      cmd.llo = (cb == `GBC_CMD_LLO);
      cmd.dcl = (cb == `GBC_CMD_DCL);
      cmd.spe = (cb == `GBC_CMD_SPE);
      cmd.spd = (cb == `GBC_CMD_SPD);
    end
  end

  // Avalon slave: one wait cycle, read data from a flop
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign wr_en = AVS_WRITE & ack_q;

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    rd_d = '0;
    case (AVS_ADDRESS)
      `GBC_CTRL_OFS: begin
        rd_d[`GBC_CTRL_ARM_BUS] = cfg_q.arm_bus;
        rd_d[`GBC_CTRL_ARM_MAN] = cfg_q.arm_manual;
        rd_d[`GBC_CTRL_AUTO_OFF] = cfg_q.auto_off;
        rd_d[`GBC_CTRL_ADDR_MSB:`GBC_CTRL_ADDR_LSB] = cfg_q.addr;
      end
      `GBC_STATUS_OFS: begin
        rd_d[`GBC_ST_REMOTE] = st_q.remote;
        rd_d[`GBC_ST_LOCKOUT] = st_q.lockout;
        rd_d[`GBC_ST_TALK] = st_q.talk;
        rd_d[`GBC_ST_LISTEN] = st_q.listen;
        rd_d[`GBC_ST_SRQ] = st_q.srq;
        rd_d[`GBC_ST_SPOLL] = st_q.spoll;
      end
      `GBC_STB_OFS: begin
        rd_d[7:0] = stb_q;
      end
      default: begin
        rd_d = '0;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      rd_q <= '0;
    end else if (AVS_READ && !ack_q) begin
      rd_q <= rd_d;
    end
  end

  assign AVS_READDATA = rd_q;

  // Configuration: reset only at power-up, never by bus clears
  // settings kept
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      cfg_q.arm_bus <= 1'b0;
      cfg_q.arm_manual <= 1'b0;
      cfg_q.auto_off <= 1'b0;
      cfg_q.addr <= `GBC_ADDR_RST;
    end else if (wr_en && AVS_ADDRESS == `GBC_CTRL_OFS) begin
      cfg_q.arm_bus <= AVS_WRITEDATA[`GBC_CTRL_ARM_BUS];
      cfg_q.arm_manual <= AVS_WRITEDATA[`GBC_CTRL_ARM_MAN];
      cfg_q.auto_off <= AVS_WRITEDATA[`GBC_CTRL_AUTO_OFF];
      cfg_q.addr <= AVS_WRITEDATA[`GBC_CTRL_ADDR_MSB:`GBC_CTRL_ADDR_LSB];
    end
  end

  // Remote and local state
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      st_q.remote <= 1'b0;
    end else if (ifc || !ren) begin
      st_q.remote <= 1'b0;
    end else if (cmd.mla) begin
      st_q.remote <= 1'b1;
    end else if (cmd.gtl && st_q.listen) begin
      st_q.remote <= 1'b0;
    end else if (k_local && !st_q.lockout) begin
      st_q.remote <= 1'b0;
    end
  end

  // Lockout; dropping remote enable also ends it
  always_ff @(posedge MCLK) begin
    if (!RESET_N || !ren) begin
      st_q.lockout <= 1'b0;
    end else if (cmd.gtl && st_q.listen) begin
      st_q.lockout <= 1'b0;
    end else if (cmd.llo) begin
      st_q.lockout <= 1'b1;
    end
  end

  // Talker state
  always_ff @(posedge MCLK) begin
    if (!RESET_N || ifc) begin
      st_q.talk <= 1'b0;
    end else if (cmd.mta) begin
      st_q.talk <= 1'b1;
    end else if (cmd.unt || cmd.mla) begin
      st_q.talk <= 1'b0;
    end
  end

  // Listener state
  always_ff @(posedge MCLK) begin
    if (!RESET_N || ifc) begin
      st_q.listen <= 1'b0;
    end else if (cmd.mla) begin
      st_q.listen <= 1'b1;
    end else if (cmd.unl || cmd.mta) begin
      st_q.listen <= 1'b0;
    end
  end

  // Serial poll mode
  always_ff @(posedge MCLK) begin
    if (!RESET_N || ifc) begin
      st_q.spoll <= 1'b0;
    end else if (cmd.spe) begin
      st_q.spoll <= 1'b1;
    end else if (cmd.spd) begin
      st_q.spoll <= 1'b0;
    end
  end

  // Service request; a new cause beats a clear in the same cycle
  assign poll_rd = TALK_RD & st_q.spoll & st_q.talk;

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= SRQ_COND;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      st_q.srq <= 1'b0;
    end else if (SRQ_COND && !cond_q) begin
      st_q.srq <= 1'b1;
    end else if (poll_rd || !SRQ_COND) begin
      st_q.srq <= 1'b0;
    end
  end

  // Poll byte kept current so it can be read at any moment
  // poll any time
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      stb_q <= '0;
    end else begin
      stb_q <= STB_IN;
      stb_q[`GBC_STB_RSV] <= st_q.srq;
    end
  end

  assign SPOLL_BYTE = stb_q;

  // Open-drain service request line
  assign SRQ_O = 1'b0;
  assign SRQ_OE_N = ~st_q.srq;

  // Bus driven events, all registered one-cycle pulses
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      DEV_CLEAR <= 1'b0;
      ARM_EVENT <= 1'b0;
      MEAS_START <= 1'b0;
      MEAS_REJECT <= 1'b0;
      MEAS_ABORT <= 1'b0;
    end else begin
      DEV_CLEAR <= cmd.dcl | (cmd.sdc & st_q.listen);
      ARM_EVENT <= cmd.get & st_q.listen & cfg_q.arm_bus;
      MEAS_START <= MEAS_CMD & st_q.remote;
      MEAS_REJECT <= MEAS_CMD & ~st_q.remote;
      MEAS_ABORT <= ifc_rise;
    end
  end

  // Front panel gating
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      OUT_SET_ON <= 1'b0;
      OUT_SET_OFF <= 1'b0;
      TRIG_KEY_EV <= 1'b0;
      PANEL_KEY_EV <= '0;
      DISP_RESTORE <= 1'b0;
    end else begin
      OUT_SET_OFF <= (k_output & OUTPUT_IS_ON)
                     | (MEAS_DONE & cfg_q.auto_off & OUTPUT_IS_ON & ~ifc);
      OUT_SET_ON <= k_output & ~OUTPUT_IS_ON & ~st_q.lockout;
      TRIG_KEY_EV <= k_trig & ~st_q.lockout & (~st_q.remote | cfg_q.arm_manual);
      PANEL_KEY_EV <= st_q.lockout || st_q.remote ? '0 : k_other;
      DISP_RESTORE <= k_local & st_q.remote & ~st_q.lockout;
    end
  end

  // Indicators follow the state flops
  // remote indicator
  assign REMOTE_IND = st_q.remote;
  assign TALK_IND = st_q.talk;
  assign LISTEN_IND = st_q.listen;
  assign SRQ_IND = st_q.srq;
  assign LOCKOUT_IND = st_q.lockout;

endmodule

`default_nettype wire

/* testbench/gbc_top_assertions.sv */
// Port-level checks for the bus command state logic
`timescale 1ns/1ns
`default_nettype none
module gbc_top_assertions #(
  parameter int NKEY = 4
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Bus side
  input wire logic IFC_N,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_BYTE,
  input wire logic TALK_RD,
  input wire logic SRQ_COND,
  input wire logic SRQ_OE_N,
  // Pulses and indicators
  input wire logic MEAS_START,
  input wire logic DEV_CLEAR,
  input wire logic OUT_SET_ON,
  input wire logic TRIG_KEY_EV,
  input wire logic [NKEY-1:0] PANEL_KEY_EV,
  input wire logic REMOTE_IND,
  input wire logic TALK_IND,
  input wire logic LISTEN_IND,
  input wire logic SRQ_IND,
  input wire logic LOCKOUT_IND
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  sequence s_ifc_held;
    !IFC_N [*4];
  endsequence
  property p_idle;
    $rose(RESET_N) |-> !(REMOTE_IND | LOCKOUT_IND | TALK_IND | LISTEN_IND | SRQ_IND);
  endproperty
  a_idle: assert property (p_idle) else $error("not idle after reset");
  property p_apart;
    !(TALK_IND && LISTEN_IND);
  endproperty
  a_apart: assert property (p_apart) else $error("talk and listen both on");
  property p_enter;
    $rose(REMOTE_IND) |-> LISTEN_IND && $past(CMD_VALID) && $past(CMD_BYTE[6:5]) == 2'h1;
  endproperty
  a_enter: assert property (p_enter) else $error("remote without listen address");
  property p_ifc;
    s_ifc_held |=> !(REMOTE_IND | TALK_IND | LISTEN_IND);
  endproperty
  a_ifc: assert property (p_ifc) else $error("clear left state active");
  property p_dclr;
    DEV_CLEAR |-> $past(CMD_VALID) && (($past(CMD_BYTE) & 8'h7f) inside {8'h14, 8'h04});
  endproperty
  a_dclr: assert property (p_dclr) else $error("device clear without cause");
  property p_srq_set;
    $rose(SRQ_COND) |-> ##[1:2] (SRQ_IND && !SRQ_OE_N);
  endproperty
  a_srq_set: assert property (p_srq_set) else $error("service request not raised");
  property p_srq_hold;
    SRQ_IND && SRQ_COND && !TALK_RD && !$past(TALK_RD) |=> SRQ_IND;
  endproperty
  a_srq_hold: assert property (p_srq_hold) else $error("service request dropped");
  property p_lock;
    LOCKOUT_IND && $past(LOCKOUT_IND) |-> !OUT_SET_ON && !TRIG_KEY_EV && PANEL_KEY_EV == '0;
  endproperty
  a_lock: assert property (p_lock) else $error("key passed under lockout");
  property p_rem_keys;
    REMOTE_IND && $past(REMOTE_IND) |-> PANEL_KEY_EV == '0;
  endproperty
  a_rem_keys: assert property (p_rem_keys) else $error("panel key passed in remote");
  property p_meas;
    MEAS_START |-> $past(REMOTE_IND);
  endproperty
  a_meas: assert property (p_meas) else $error("measurement started in local");
endmodule
`default_nettype wire

/* testbench/gbc_ctl.sv */
// Behavioural bus controller facing the instrument
`timescale 1ns/1ns
`default_nettype none
module gbc_ctl (
  // Clock
  input wire logic clk,
  // Bus lines
  output logic ren_n,
  output logic ifc_n,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic talk_rd
);
  initial begin
    ren_n = 1'b1;
    ifc_n = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    talk_rd = 1'b0;
  end
  // only allowed commands during a bus-armed run
  task send(input logic [7:0] b);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // Stale byte inverted so nobody leans on it
    cmd_byte <= ~b;
    repeat (2) @(posedge clk);
  endtask
  task set_ren(input logic v);
    @(posedge clk);
    ren_n <= v;
    repeat (4) @(posedge clk);
  endtask
  // clear held 100 us, 1000 cycles
  task clear_bus();
    @(posedge clk);
    ifc_n <= 1'b0;
    repeat (1000) @(posedge clk);
    ifc_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task poll_read();
    @(posedge clk);
    talk_rd <= 1'b1;
    @(posedge clk);
    talk_rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the bus command state logic
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import gbc_pkg::*;
  logic clk, rst_n, rd, wr;
  logic cond, ison, mcmd, mdone;
  logic [3:0] adr;
  logic [31:0] wd;
  logic [31:0] q, rdata;
  logic [6:0] keys;
  logic [7:0] stb;
  logic [9:0] seen;
  logic [7:0] cb, spb;
  logic wreq, srq_o, oe_n, ren_n, ifc_n, cv, trd;
  logic mst, mrej, mab, arm, oon, ooff, tkey, dclr, disp, remote_indicator, talk, lsn, srq, lock;
  logic [3:0] pk;
  int n_mismatch = 0;
  int total_checks = 0;
  always #50 clk = ~clk;
  gbc_ctl u_gbc_ctl (.clk(clk), .ren_n(ren_n), .ifc_n(ifc_n), .cmd_valid(cv), .cmd_byte(cb),
    .talk_rd(trd));
  gbc_top #(.NKEY(4)) u_gbc_top (.MCLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .REN_N(ren_n), .IFC_N(ifc_n), .SRQ_O(srq_o), .SRQ_OE_N(oe_n),
    .CMD_VALID(cv), .CMD_BYTE(cb), .TALK_RD(trd), .STB_IN(stb), .SRQ_COND(cond),
    .SPOLL_BYTE(spb), .KEY_LOCAL(keys[6]), .KEY_OUTPUT(keys[5]), .KEY_TRIG(keys[4]),
    .KEY_OTHER(keys[3:0]), .MEAS_CMD(mcmd), .MEAS_DONE(mdone), .OUTPUT_IS_ON(ison),
    .MEAS_START(mst), .MEAS_REJECT(mrej), .MEAS_ABORT(mab), .ARM_EVENT(arm),
    .OUT_SET_ON(oon), .OUT_SET_OFF(ooff), .TRIG_KEY_EV(tkey), .PANEL_KEY_EV(pk),
    .DEV_CLEAR(dclr), .DISP_RESTORE(disp), .REMOTE_IND(remote_indicator), .TALK_IND(talk),
    .LISTEN_IND(lsn), .SRQ_IND(srq), .LOCKOUT_IND(lock));
  // One-cycle pulses are caught here, cleared by pchk
  // Held off in reset, when outputs are still unknown
  always @(posedge clk) begin
    if (rst_n) begin
      seen <= seen | {mst, mrej, mab, arm, oon, ooff, tkey, dclr, disp, |pk};
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic ichk(input logic [4:0] e);
    @(negedge clk);
    chk("indicators", {27'h0, remote_indicator, lock, talk, lsn, srq}, {27'h0, e});
  endtask
  task automatic pchk(input logic [9:0] e);
    @(negedge clk);
    chk("pulses", {22'h0, seen}, {22'h0, e});
    seen = 10'h000;
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic press(input logic [6:0] k);
    @(posedge clk);
    keys <= k;
    repeat (6) @(posedge clk);
    keys <= 7'h00;
    repeat (2) @(posedge clk);
  endtask
  task automatic meas(input logic done);
    @(posedge clk);
    mcmd <= ~done;
    mdone <= done;
    @(posedge clk);
    mcmd <= 1'b0;
    mdone <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset();
    ichk(5'h00);
    av(1'b1, 4'hc, 32'hffff_ffff);
    av(1'b0, 4'h0, 32'h0000_0000);
    chk("ctrl", q, 32'h0000_1900);
    av(1'b0, 4'hc, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_addr();
    u_gbc_ctl.set_ren(1'b0);
    u_gbc_ctl.send(8'h38);
    ichk(5'h00);
    u_gbc_ctl.send(8'h39);
    ichk(5'h12);
    u_gbc_ctl.send(8'h59);
    ichk(5'h14);
    u_gbc_ctl.send(8'h5f);
    ichk(5'h10);
    u_gbc_ctl.send(8'h39);
    ichk(5'h12);
    u_gbc_ctl.send(8'h3f);
    ichk(5'h10);
    $display("address test done");
  endtask
  task automatic t_keys();
    press(7'h01);
    pchk(10'h000);
    press(7'h20);
    pchk(10'h020);
    press(7'h10);
    pchk(10'h000);
    av(1'b1, 4'h0, 32'h0000_1902);
    press(7'h10);
    pchk(10'h008);
    press(7'h40);
    pchk(10'h002);
    ichk(5'h00);
    press(7'h01);
    pchk(10'h001);
    press(7'h0e);
    pchk(10'h001);
    $display("keys test done");
  endtask
  task automatic t_lock();
    u_gbc_ctl.send(8'h39);
    u_gbc_ctl.send(8'h11);
    ichk(5'h1a);
    press(7'h40);
    ichk(5'h1a);
    @(posedge clk);
    ison <= 1'b1;
    press(7'h21);
    pchk(10'h010);
    u_gbc_ctl.send(8'h01);
    ichk(5'h02);
    @(posedge clk);
    ison <= 1'b0;
    $display("lockout test done");
  endtask
  task automatic t_clear();
    u_gbc_ctl.send(8'h3f);
    u_gbc_ctl.send(8'h14);
    pchk(10'h004);
    u_gbc_ctl.send(8'h04);
    pchk(10'h000);
    u_gbc_ctl.send(8'h39);
    u_gbc_ctl.send(8'h04);
    pchk(10'h004);
    av(1'b0, 4'h0, 32'h0000_0000);
    chk("ctrl", q, 32'h0000_1902);
    u_gbc_ctl.send(8'h08);
    pchk(10'h000);
    av(1'b1, 4'h0, 32'h0000_1901);
    u_gbc_ctl.send(8'h08);
    pchk(10'h040);
    meas(1'b0);
    pchk(10'h200);
    // run ends before any other command
    meas(1'b1);
    $display("clear and trigger test done");
  endtask
  task automatic t_poll();
    @(posedge clk);
    cond <= 1'b1;
    repeat (3) @(posedge clk);
    ichk(5'h13);
    chk("poll byte", {24'h0, spb}, 32'h0000_0045);
    chk("srq pin", {30'h0, srq_o, oe_n}, 32'h0000_0000);
    av(1'b0, 4'h4, 32'h0000_0000);
    chk("status", q, 32'h0000_0019);
    av(1'b0, 4'h8, 32'h0000_0000);
    chk("poll reg", q, 32'h0000_0045);
    u_gbc_ctl.send(8'h18);
    u_gbc_ctl.send(8'h59);
    u_gbc_ctl.poll_read();
    ichk(5'h14);
    chk("poll byte", {24'h0, spb}, 32'h0000_0005);
    chk("srq pin", {30'h0, srq_o, oe_n}, 32'h0000_0001);
    u_gbc_ctl.send(8'h19);
    stb <= 8'hc3;
    cond <= 1'b0;
    repeat (2) @(posedge clk);
    cond <= 1'b1;
    repeat (3) @(posedge clk);
    ichk(5'h15);
    chk("poll byte", {24'h0, spb}, 32'h0000_00c3);
    @(posedge clk);
    cond <= 1'b0;
    repeat (3) @(posedge clk);
    ichk(5'h14);
    chk("poll byte", {24'h0, spb}, 32'h0000_0083);
    $display("poll test done");
  endtask
  task automatic t_ifc();
    u_gbc_ctl.send(8'h11);
    ison <= 1'b1;
    av(1'b1, 4'h0, 32'h0000_1905);
    @(negedge clk);
    seen = 10'h000;
    fork
      u_gbc_ctl.clear_bus();
      begin
        repeat (20) @(posedge clk);
        meas(1'b1);
      end
    join
    pchk(10'h080);
    ichk(5'h08);
    av(1'b0, 4'h0, 32'h0000_0000);
    chk("ctrl", q, 32'h0000_1905);
    meas(1'b1);
    pchk(10'h010);
    meas(1'b0);
    pchk(10'h100);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    ichk(5'h00);
    $display("interface clear test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    cond = 1'b0;
    ison = 1'b0;
    mcmd = 1'b0;
    mdone = 1'b0;
    adr = 4'h0;
    wd = 32'h0000_0000;
    keys = 7'h00;
    stb = 8'h05;
    seen = 10'h000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_addr();
    t_keys();
    t_lock();
    t_clear();
    t_poll();
    t_ifc();
    give_verdict();
  end
  // Whole run is near 1300 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
bind gbc_top gbc_top_assertions #(.NKEY(NKEY)) u_gbc_top_assertions (.*);
`default_nettype wire
